/* sfw_pkg.sv */
package sfw_pkg;

  // Opcodes handled by the sequencer
  localparam logic [7:0] OP_WRAP_SET  = 8'h77;
  localparam logic [7:0] OP_PAGE_WR   = 8'h02;
  localparam logic [7:0] OP_QPAGE_WR  = 8'h32;
  localparam logic [7:0] OP_SECT_CLR  = 8'h20;
  localparam logic [7:0] OP_BLK_CLR   = 8'h52;

  // Address layout
  localparam int          ADDR_W       = 24;
  localparam int          PAGE_BYTES   = 256;
  localparam int          SECT_LSB     = 12;
  localparam int          BLK_LSB      = 15;
  localparam int          WRAP_BYTE_HI = 6;
  localparam int          WRAP_BYTE_LO = 4;
  localparam int          WRAP_MIN     = 8;

  // Reset values of the wrap setting
  localparam logic        WRAP_DIS_RST = 1'b1;
  localparam logic [1:0]  WRAP_LEN_RST = 2'h0;

  // Self-timed cycle lengths
  localparam int          CLK_MHZ      = 40;
  localparam int          PROG_TIME_US = 700;
  localparam int          SECT_TIME_US = 50000;
  localparam int          BLK_TIME_US  = 150000;
  localparam int          PROG_CYCLES  = PROG_TIME_US * CLK_MHZ;
  localparam int          SECT_CYCLES  = SECT_TIME_US * CLK_MHZ;
  localparam int          BLK_CYCLES   = BLK_TIME_US * CLK_MHZ;
  localparam int          TMR_W        = 24;

  // Kind of internal cycle
  localparam logic [1:0]  KIND_PROG    = 2'h0;
  localparam logic [1:0]  KIND_SECT    = 2'h1;
  localparam logic [1:0]  KIND_BLK     = 2'h2;

  // Frame parser states
  typedef enum logic [3:0] {
    ST_OPC  = 4'b0001,
    ST_ADDR = 4'b0010,
    ST_DATA = 4'b0100,
    ST_SKIP = 4'b1000
  } sfw_frame_e;

endpackage

/* sfw_link_if.sv */
`timescale 1ns/1ps
interface sfw_link_if;
  logic       cs_n_lvl;
  logic       cs_fall;
  logic       cs_rise;
  logic       sclk_rise;
  logic [3:0] io_smp;
  logic       tmr_start;
  logic [1:0] tmr_kind;
  logic       tmr_busy;

  modport sync_mp (output cs_n_lvl, output cs_fall, output cs_rise, output sclk_rise,
                   output io_smp);
  modport core_mp (input cs_n_lvl, input cs_fall, input cs_rise, input sclk_rise,
                   input io_smp, output tmr_start, output tmr_kind, input tmr_busy);
  modport tmr_mp  (input tmr_start, input tmr_kind, output tmr_busy);
endinterface

/* sfw_pin_sync.sv */
`timescale 1ns/1ps
module sfw_pin_sync (
  input  wire logic   clk,
  input  wire logic   srst,
  input  wire logic   cs_n_pin,
  input  wire logic   sclk_pin,
  input  wire logic [3:0] io_pin_in,
  sfw_link_if.sync_mp lnk
);
  logic [5:0] s1_reg;
  logic [5:0] s2_reg;
  logic [5:0] s3_reg;
  logic [5:0] stab_reg;
  logic [5:0] stab_next;
  logic       rise_reg;
  logic       fall_cs_reg;
  logic       rise_cs_reg;
  logic [3:0] io_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Three-stage synchronisers; a level counts once stages two and three agree
  always_ff @(posedge clk) begin
    if (srst) begin
      s1_reg <= 6'h01;
      s2_reg <= 6'h01;
      s3_reg <= 6'h01;
    end else begin
      s1_reg <= {io_pin_in, sclk_pin, cs_n_pin};
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  // Disagreeing stages keep the old level, filtering single-sample glitches
  assign stab_next = (s2_reg & s3_reg) | (stab_reg & (s2_reg | s3_reg));

  ////////////////////////////////////////////////////////////////////////////
  // Edge events, one cycle each; data is taken with the clock rise
  always_ff @(posedge clk) begin
    if (srst) begin
      stab_reg    <= 6'h01;
      rise_reg    <= 1'b0;
      fall_cs_reg <= 1'b0;
      rise_cs_reg <= 1'b0;
      io_reg      <= 4'h0;
    end else begin
      stab_reg    <= stab_next;
      rise_reg    <= stab_next[1] & ~stab_reg[1];
      fall_cs_reg <= ~stab_next[0] & stab_reg[0];
      rise_cs_reg <= stab_next[0] & ~stab_reg[0];
      if (stab_next[1] & ~stab_reg[1]) begin
        io_reg <= stab_next[5:2];
      end
    end
  end

  assign lnk.cs_n_lvl  = stab_reg[0];
  assign lnk.sclk_rise = rise_reg;
  assign lnk.cs_fall   = fall_cs_reg;
  assign lnk.cs_rise   = rise_cs_reg;
  assign lnk.io_smp    = io_reg;
endmodule // sfw_pin_sync

/* sfw_cycle_timer.sv */
`timescale 1ns/1ps
module sfw_cycle_timer #(
  parameter int PROG_CYC = sfw_pkg::PROG_CYCLES,
  parameter int SECT_CYC = sfw_pkg::SECT_CYCLES,
  parameter int BLK_CYC  = sfw_pkg::BLK_CYCLES
) (
  input  wire logic  clk,
  input  wire logic  srst,
  sfw_link_if.tmr_mp lnk
);
  import sfw_pkg::*;

  logic [TMR_W-1:0] cnt_reg;
  logic             busy_reg;
  logic [TMR_W-1:0] load_val;

  // Cycle length chosen by the kind of operation
  assign load_val = (lnk.tmr_kind == KIND_PROG) ? TMR_W'(PROG_CYC - 1) :
                    (lnk.tmr_kind == KIND_SECT) ? TMR_W'(SECT_CYC - 1) :
                                                  TMR_W'(BLK_CYC - 1);

  ////////////////////////////////////////////////////////////////////////////
  // Down counter; a start while busy is dropped
  always_ff @(posedge clk) begin
    if (srst) begin
      cnt_reg  <= '0;
      busy_reg <= 1'b0;
    end else if (lnk.tmr_start && !busy_reg) begin
      cnt_reg  <= load_val;
      busy_reg <= 1'b1;
    end else if (busy_reg) begin
      cnt_reg  <= cnt_reg - TMR_W'(1);
      busy_reg <= (cnt_reg != '0);
    end
  end

  assign lnk.tmr_busy = busy_reg;
endmodule // sfw_cycle_timer

/* sfw_flash_seq.sv */
`timescale 1ns/1ps
module sfw_flash_seq #(
  parameter int PROG_CYC = sfw_pkg::PROG_CYCLES,
  parameter int SECT_CYC = sfw_pkg::SECT_CYCLES,
  parameter int BLK_CYC  = sfw_pkg::BLK_CYCLES
) (
  input  wire logic                      clk,
  input  wire logic                      srst,
  input  wire logic                      cs_n_pin,
  input  wire logic                      sclk_pin,
  input  wire logic [3:0]                io_pin_in,
  input  wire logic                      write_latch_set_cmd,
  input  wire logic                      four_wire_command_mode,
  input  wire logic                      quad_io_enable,
  input  wire logic [4:0]                protect_level_bits,
  input  wire logic                      rd_param_load,
  input  wire logic [1:0]                rd_param_len,
  input  wire logic                      rd_load,
  input  wire logic [sfw_pkg::ADDR_W-1:0] rd_start_addr,
  input  wire logic                      rd_step,
  input  wire logic                      rd_quad_io,
  input  wire logic                      rd_wrapped_cmd,
  output logic                           write_latch_flag,
  output logic                           busy_flag,
  output logic                           wrap_disable_bit,
  output logic [1:0]                     wrap_length_field,
  output logic [sfw_pkg::ADDR_W-1:0]     rd_addr,
  output logic                           mem_wr_en,
  output logic [sfw_pkg::ADDR_W-1:0]     mem_wr_addr,
  output logic [7:0]                     mem_wr_data,
  output logic                           erase_go,
  output logic [sfw_pkg::ADDR_W-1:0]     erase_addr,
  output logic                           erase_is_block
);
  import sfw_pkg::*;

  sfw_link_if lnk ();

  sfw_pin_sync u_sync (
    .clk       (clk),
    .srst      (srst),
    .cs_n_pin  (cs_n_pin),
    .sclk_pin  (sclk_pin),
    .io_pin_in (io_pin_in),
    .lnk       (lnk.sync_mp)
  );

  sfw_cycle_timer #(
    .PROG_CYC (PROG_CYC),
    .SECT_CYC (SECT_CYC),
    .BLK_CYC  (BLK_CYC)
  ) u_tmr (
    .clk  (clk),
    .srst (srst),
    .lnk  (lnk.tmr_mp)
  );

  // Protection: level n covers the top 2^(n-1) 64 KB blocks, 9 and up all
  function automatic logic prot_hit(input logic [4:0] lvl, input logic [ADDR_W-1:0] a);
    logic [7:0] m;
    m = 8'(8'hFF << (lvl - 5'd1));
    if (lvl == 5'd0) begin
      prot_hit = 1'b0;
    end else if (lvl >= 5'd9) begin
      prot_hit = 1'b1;
    end else begin
      prot_hit = ((a[23:16] & m) == m);
    end
  endfunction

  sfw_frame_e        state_reg;
  sfw_frame_e        state_next;
  logic [7:0]        op_reg;
  logic [7:0]        sh_reg;
  logic [2:0]        bit_reg;
  logic [1:0]        abyte_reg;
  logic [1:0]        dcnt_reg;
  logic              quad_reg;
  logic [ADDR_W-1:0] addr_reg;
  logic [7:0]        ptr_reg;
  logic [7:0]        page_buf [PAGE_BYTES];
  logic [255:0]      mask_reg;
  logic              wel_reg;
  logic              wrap_dis_reg;
  logic [1:0]        wrap_len_reg;
  logic [ADDR_W-1:0] rd_addr_reg;
  logic              prog_run_reg;
  logic [7:0]        idx_reg;
  logic [15:0]       page_reg;
  logic              wr_en_reg;
  logic [ADDR_W-1:0] wr_addr_reg;
  logic [7:0]        wr_data_reg;
  logic              er_go_reg;
  logic [ADDR_W-1:0] er_addr_reg;
  logic              er_blk_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Bit assembly: one line per edge, four in quad phases
  wire       clk_edge  = lnk.sclk_rise & ~lnk.cs_n_lvl;
  wire [7:0] sh_next   = quad_reg ? {sh_reg[3:0], lnk.io_smp} : {sh_reg[6:0], lnk.io_smp[0]};
  wire [2:0] bit_next  = bit_reg + (quad_reg ? 3'h4 : 3'h1);
  wire       byte_done = clk_edge & (bit_next == 3'h0);
  wire       busy      = lnk.tmr_busy;

  // Opcode classes
  wire op_prog  = (op_reg == OP_PAGE_WR) | (op_reg == OP_QPAGE_WR);
  wire op_erase = (op_reg == OP_SECT_CLR) | (op_reg == OP_BLK_CLR);
  wire op_wrap  = (op_reg == OP_WRAP_SET);
  wire new_prog = (sh_next == OP_PAGE_WR) | (sh_next == OP_QPAGE_WR);
  wire new_known = new_prog | (sh_next == OP_SECT_CLR) | (sh_next == OP_BLK_CLR) |
                   (sh_next == OP_WRAP_SET);
  wire new_quad_ok = (sh_next != OP_QPAGE_WR) | quad_io_enable;
  wire start_ok  = byte_done & (state_reg == ST_OPC) & new_known & new_quad_ok & ~busy;

  // Erase base drops the bits inside the sector or block
  wire               blk_sel   = (op_reg == OP_BLK_CLR);
  wire [ADDR_W-1:0]  er_base   = blk_sel ? {addr_reg[23:BLK_LSB], 15'h0000}
                                         : {addr_reg[23:SECT_LSB], 12'h000};

  // Frame end on a byte boundary after the address
  wire frame_end = lnk.cs_rise & (state_reg == ST_DATA) & (bit_reg == 3'h0);
  wire go_prog   = frame_end & op_prog & (dcnt_reg != 2'h0) & wel_reg & ~busy
                   & ~prot_hit(protect_level_bits, addr_reg);
  wire go_erase  = frame_end & op_erase & (dcnt_reg == 2'h0) & wel_reg & ~busy
                   & ~prot_hit(protect_level_bits, er_base);
  wire go_wrap   = frame_end & op_wrap & (dcnt_reg == 2'h1);
  wire buf_we    = byte_done & (state_reg == ST_DATA) & op_prog;

  ////////////////////////////////////////////////////////////////////////////
  // Frame parser next state
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_OPC:  state_next = byte_done ? (start_ok ? ST_ADDR : ST_SKIP) : ST_OPC;
      ST_ADDR: state_next = (byte_done && abyte_reg == 2'h2) ? ST_DATA : ST_ADDR;
      ST_DATA: state_next = ST_DATA;
      ST_SKIP: state_next = ST_SKIP;
      default: state_next = ST_SKIP;
    endcase
  end

  // Each frame restarts at the select fall
  always_ff @(posedge clk) begin
    if (srst) begin
      state_reg <= ST_SKIP;
      bit_reg   <= 3'h0;
      sh_reg    <= 8'h00;
    end else if (lnk.cs_fall) begin
      state_reg <= ST_OPC;
      bit_reg   <= 3'h0;
    end else if (clk_edge) begin
      state_reg <= state_next;
      bit_reg   <= bit_next;
      sh_reg    <= sh_next;
    end
  end

  // Opcode, quad phase and byte counters
  always_ff @(posedge clk) begin
    if (srst || lnk.cs_fall) begin
      op_reg    <= 8'h00;
      quad_reg  <= 1'b0;
      abyte_reg <= 2'h0;
      dcnt_reg  <= 2'h0;
    end else if (start_ok) begin
      op_reg    <= sh_next;
      quad_reg  <= (sh_next == OP_QPAGE_WR);
    end else if (byte_done && state_reg == ST_ADDR) begin
      abyte_reg <= abyte_reg + 2'h1;
    end else if (byte_done && state_reg == ST_DATA && dcnt_reg != 2'h2) begin
      dcnt_reg  <= dcnt_reg + 2'h1; // Saturates: only zero, one, many matter
    end
  end

  // Address shift; the page offset pointer starts at A7-A0
  always_ff @(posedge clk) begin
    if (srst) begin
      addr_reg <= '0;
      ptr_reg  <= 8'h00;
    end else if (byte_done && state_reg == ST_ADDR) begin
      addr_reg <= {addr_reg[15:0], sh_next};
      ptr_reg  <= sh_next;
    end else if (buf_we) begin
      ptr_reg  <= ptr_reg + 8'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Page buffer; later bytes overwrite earlier ones at the same offset
  always_ff @(posedge clk) begin
    if (buf_we) begin
      page_buf[ptr_reg] <= sh_next;
    end
  end

  // Written-byte mask, cleared when a program frame opens
  always_ff @(posedge clk) begin
    if (srst || (start_ok && new_prog)) begin
      mask_reg <= '0;
    end else if (buf_we) begin
      mask_reg[ptr_reg] <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Write latch: set command wins over the clear at cycle start
  always_ff @(posedge clk) begin
    if (srst) begin
      wel_reg <= 1'b0;
    end else if (write_latch_set_cmd) begin
      wel_reg <= 1'b1;
    end else if (go_prog || go_erase) begin
      wel_reg <= 1'b0;
    end
  end

  // Timer start on the select rise of an accepted program or erase frame
  assign lnk.tmr_start = go_prog | go_erase;
  assign lnk.tmr_kind  = go_prog ? KIND_PROG : (blk_sel ? KIND_BLK : KIND_SECT);

  ////////////////////////////////////////////////////////////////////////////
  // Write-out walks the page once; only marked offsets reach the array
  always_ff @(posedge clk) begin
    if (srst) begin
      prog_run_reg <= 1'b0;
      idx_reg      <= 8'h00;
      page_reg     <= 16'h0000;
    end else if (go_prog) begin
      prog_run_reg <= 1'b1;
      idx_reg      <= 8'h00;
      page_reg     <= addr_reg[23:8];
    end else if (prog_run_reg) begin
      idx_reg      <= idx_reg + 8'h01;
      prog_run_reg <= (idx_reg != 8'hFF);
    end
  end

  // Array write port, registered
  always_ff @(posedge clk) begin
    if (srst) begin
      wr_en_reg   <= 1'b0;
      wr_addr_reg <= '0;
      wr_data_reg <= 8'h00;
    end else begin
      wr_en_reg   <= prog_run_reg & mask_reg[idx_reg];
      wr_addr_reg <= {page_reg, idx_reg};
      wr_data_reg <= page_buf[idx_reg];
    end
  end

  // Erase request, one pulse at cycle start
  always_ff @(posedge clk) begin
    if (srst) begin
      er_go_reg   <= 1'b0;
      er_addr_reg <= '0;
      er_blk_reg  <= 1'b0;
    end else begin
      er_go_reg   <= go_erase;
      if (go_erase) begin
        er_addr_reg <= er_base;
        er_blk_reg  <= blk_sel;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Wrap setting; the parameter load only retunes the length
  always_ff @(posedge clk) begin
    if (srst) begin
      wrap_dis_reg <= WRAP_DIS_RST;
      wrap_len_reg <= WRAP_LEN_RST;
    end else if (go_wrap) begin
      wrap_dis_reg <= sh_reg[WRAP_BYTE_LO];
      wrap_len_reg <= sh_reg[WRAP_BYTE_HI:WRAP_BYTE_LO+1];
    end else if (rd_param_load) begin
      wrap_len_reg <= rd_param_len;
    end
  end

  // Wrap applies to standard quad reads, or to the wrapped read in four-wire mode
  wire       rd_wrap_on = four_wire_command_mode ? rd_wrapped_cmd
                                                 : (rd_quad_io & ~wrap_dis_reg);
  wire [8:0] sec_size   = 9'(WRAP_MIN) << wrap_len_reg;
  wire [7:0] sec_mask   = 8'(sec_size - 9'h001);
  wire [7:0] low_inc    = rd_addr_reg[7:0] + 8'h01;
  wire [ADDR_W-1:0] rd_wrap_next = {rd_addr_reg[23:8],
                                    (rd_addr_reg[7:0] & ~sec_mask) | (low_inc & sec_mask)};

  // Read address sequencer; stepping stays inside the section while rd_wrap_on, else counts up linearly
  always_ff @(posedge clk) begin
    if (srst) begin
      rd_addr_reg <= '0;
    end else if (rd_load) begin
      rd_addr_reg <= rd_start_addr;
    end else if (rd_step) begin
      rd_addr_reg <= rd_wrap_on ? rd_wrap_next : rd_addr_reg + ADDR_W'(1);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign write_latch_flag  = wel_reg;
  assign busy_flag         = busy;
  assign wrap_disable_bit  = wrap_dis_reg;
  assign wrap_length_field = wrap_len_reg;
  assign rd_addr           = rd_addr_reg;
  assign mem_wr_en         = wr_en_reg;
  assign mem_wr_addr       = wr_addr_reg;
  assign mem_wr_data       = wr_data_reg;
  assign erase_go          = er_go_reg;
  assign erase_addr        = er_addr_reg;
  assign erase_is_block    = er_blk_reg;
endmodule // sfw_flash_seq

/* sfw_host_model.sv */
`timescale 1ns/1ps
module sfw_host_model (
  output logic       cs_n_pin,
  output logic       sclk_pin,
  output logic [3:0] io_pin_in
);
  localparam time HALF = 100ns;
  //////////////////////////////////////////////////
  // Idle: select high, clock parked low between frames
  initial begin
    cs_n_pin  = 1'b1;
    sclk_pin  = 1'b0;
    io_pin_in = 4'hA;
  end
  // Select held low through the whole frame
  task automatic frame_open();
    #(HALF) cs_n_pin <= 1'b0;
    #(HALF);
  endtask
  // Lines inverted on release so a stale level never looks valid
  task automatic frame_close();
    #(HALF) cs_n_pin <= 1'b1;
    io_pin_in <= ~io_pin_in;
    #(2*HALF);
  endtask
  // n symbols of w lines each, most significant first, set up half a period early
  task automatic send(input logic [31:0] v, input int n, input int w);
    for (int i = n - 1; i >= 0; i--) begin
      if (w == 4) io_pin_in <= v[4*i+:4];
      else io_pin_in[0] <= v[i];
      #(HALF) sclk_pin <= 1'b1;
      #(HALF) sclk_pin <= 1'b0;
    end
  endtask
endmodule // sfw_host_model

/* sfw_flash_seq_chk.sv */
`timescale 1ns/1ps
module sfw_flash_seq_chk #(
  parameter int PROG_CYC = 300,
  parameter int SECT_CYC = 200,
  parameter int BLK_CYC  = 200
) (
  input wire logic                        clk,
  input wire logic                        srst,
  input wire logic                        write_latch_set_cmd,
  input wire logic                        four_wire_command_mode,
  input wire logic                        rd_load,
  input wire logic                        rd_step,
  input wire logic                        rd_quad_io,
  input wire logic                        rd_wrapped_cmd,
  input wire logic                        write_latch_flag,
  input wire logic                        busy_flag,
  input wire logic                        wrap_disable_bit,
  input wire logic [1:0]                  wrap_length_field,
  input wire logic [sfw_pkg::ADDR_W-1:0]  rd_addr,
  input wire logic                        mem_wr_en,
  input wire logic [sfw_pkg::ADDR_W-1:0]  mem_wr_addr,
  input wire logic                        erase_go,
  input wire logic [sfw_pkg::ADDR_W-1:0]  erase_addr,
  input wire logic                        erase_is_block
);
  import sfw_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  //////////////////////////////////////////////////
  // Expected next read address inside the current section
  logic [23:0] sec_mask;
  logic [23:0] wrap_nxt;
  logic        wrap_on;
  assign sec_mask = (24'h000008 << wrap_length_field) - 24'h000001;
  assign wrap_nxt = (rd_addr & ~sec_mask) | ((rd_addr + 24'h000001) & sec_mask);
  assign wrap_on  = four_wire_command_mode ? rd_wrapped_cmd : (rd_quad_io & ~wrap_disable_bit);
  sequence s_two_wr;
    mem_wr_en ##1 mem_wr_en;
  endsequence
  property p_rst_vals;
    $fell(srst) |-> wrap_disable_bit && wrap_length_field == 2'h0 && !busy_flag
      && !write_latch_flag && !erase_go && !mem_wr_en;
  endproperty
  property p_go_busy;
    erase_go |-> $rose(busy_flag);
  endproperty
  property p_go_pulse;
    erase_go |=> !erase_go;
  endproperty
  property p_go_align;
    erase_go |-> (erase_is_block ? erase_addr[14:0] == 15'h0000 : erase_addr[11:0] == 12'h000);
  endproperty
  property p_wel_clr;
    $rose(busy_flag) && !$past(write_latch_set_cmd) |-> !write_latch_flag;
  endproperty
  property p_need_wel;
    $rose(busy_flag) |-> $past(write_latch_flag);
  endproperty
  property p_busy_hold;
    $rose(busy_flag) |-> busy_flag [*8];
  endproperty
  property p_wr_busy;
    mem_wr_en |-> busy_flag;
  endproperty
  property p_wr_page;
    s_two_wr |-> mem_wr_addr[23:8] == $past(mem_wr_addr[23:8])
      && mem_wr_addr[7:0] > $past(mem_wr_addr[7:0]);
  endproperty
  property p_rd_wrap;
    rd_step && !rd_load && wrap_on |=> rd_addr == $past(wrap_nxt);
  endproperty
  property p_rd_lin;
    rd_step && !rd_load && !wrap_on |=> rd_addr == $past(rd_addr) + 24'h000001;
  endproperty
  a_rst_vals:  assert property (p_rst_vals)  else $error("reset values wrong");
  a_go_busy:   assert property (p_go_busy)   else $error("erase pulse outside busy");
  a_go_pulse:  assert property (p_go_pulse)  else $error("erase pulse too long");
  a_go_align:  assert property (p_go_align)  else $error("erase base unaligned");
  a_wel_clr:   assert property (p_wel_clr)   else $error("latch not cleared");
  a_need_wel:  assert property (p_need_wel)  else $error("cycle without latch");
  a_busy_hold: assert property (p_busy_hold) else $error("busy too short");
  a_wr_busy:   assert property (p_wr_busy)   else $error("write outside busy");
  a_wr_page:   assert property (p_wr_page)   else $error("write left page");
  a_rd_wrap:   assert property (p_rd_wrap)   else $error("read did not wrap");
  a_rd_lin:    assert property (p_rd_lin)    else $error("read not linear");
endmodule // sfw_flash_seq_chk

bind sfw_flash_seq sfw_flash_seq_chk #(.PROG_CYC(PROG_CYC), .SECT_CYC(SECT_CYC),
  .BLK_CYC(BLK_CYC)) sfw_flash_seq_chk_inst (.clk, .srst, .write_latch_set_cmd,
  .four_wire_command_mode, .rd_load, .rd_step, .rd_quad_io, .rd_wrapped_cmd,
  .write_latch_flag, .busy_flag, .wrap_disable_bit, .wrap_length_field, .rd_addr,
  .mem_wr_en, .mem_wr_addr, .erase_go, .erase_addr, .erase_is_block);

/* sfw_flash_seq_bench.sv */
`timescale 1ns/1ps
module sfw_flash_seq_bench;
  import sfw_pkg::*;
  logic        clk = 1'b0, srst = 1'b1, write_latch_set_cmd = 1'b0;
  logic        four_wire_command_mode = 1'b0, quad_io_enable = 1'b0, rd_param_load = 1'b0;
  logic        rd_load = 1'b0, rd_step = 1'b0, rd_quad_io = 1'b0, rd_wrapped_cmd = 1'b0;
  logic [4:0]  protect_level_bits = 5'h00;
  logic [1:0]  rd_param_len = 2'h0;
  logic [23:0] rd_start_addr = 24'h000000;
  logic        cs_n_pin, sclk_pin, write_latch_flag, busy_flag, wrap_disable_bit;
  logic        mem_wr_en, erase_go, erase_is_block, go_blk;
  logic [3:0]  io_pin_in;
  logic [1:0]  wrap_length_field;
  logic [23:0] rd_addr, mem_wr_addr, erase_addr, go_addr;
  logic [7:0]  mem_wr_data;
  logic [31:0] wr_q[$];
  int          num_errors = 0, comparisons = 0;
  //////////////////////////////////////////////////
  always #12.5 clk = ~clk;
  sfw_host_model sfw_host_model_inst (.cs_n_pin, .sclk_pin, .io_pin_in);
  sfw_flash_seq #(.PROG_CYC(300), .SECT_CYC(200), .BLK_CYC(200)) sfw_flash_seq_inst (
    .clk, .srst, .cs_n_pin, .sclk_pin, .io_pin_in, .write_latch_set_cmd,
    .four_wire_command_mode, .quad_io_enable, .protect_level_bits, .rd_param_load,
    .rd_param_len, .rd_load, .rd_start_addr, .rd_step, .rd_quad_io, .rd_wrapped_cmd,
    .write_latch_flag, .busy_flag, .wrap_disable_bit, .wrap_length_field, .rd_addr,
    .mem_wr_en, .mem_wr_addr, .mem_wr_data, .erase_go, .erase_addr, .erase_is_block);
  // Record every byte written and the last erase request
  always @(posedge clk) begin
    if (mem_wr_en === 1'b1) wr_q.push_back({mem_wr_addr, mem_wr_data});
    if (erase_go === 1'b1) {go_addr, go_blk} <= {erase_addr, erase_is_block};
  end
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // One whole frame: opcode, address, optional data given in bits
  task automatic frame(input logic [7:0] op, input logic [31:0] a, input logic [31:0] d,
                       input int dn, input int w);
    sfw_host_model_inst.frame_open();
    sfw_host_model_inst.send({24'h000000, op}, 8, 1);
    sfw_host_model_inst.send(a, 24 / w, w);
    if (dn > 0) sfw_host_model_inst.send(d, dn / w, w);
    sfw_host_model_inst.frame_close();
    repeat (2) @(posedge clk);
  endtask
  // One-cycle strobes, one bit each: step, load, length load, latch set
  localparam logic [3:0] P_STEP = 4'h8, P_LOAD = 4'h4, P_PLEN = 4'h2, P_WEL = 4'h1;
  task automatic pulse(input logic [3:0] m);
    {rd_step, rd_load, rd_param_load, write_latch_set_cmd} <= m;
    @(posedge clk);
    {rd_step, rd_load, rd_param_load, write_latch_set_cmd} <= 4'h0;
    @(posedge clk);
  endtask
  task automatic wait_idle();
    for (int i = 0; i < 1000 && busy_flag !== 1'b0; i++) @(posedge clk);
    check("busy_end", busy_flag, 1'b0);
  endtask
  // Load a start address, step n times, compare the result
  task automatic rd_try(input logic [23:0] a, input int n, input logic [23:0] exp);
    rd_start_addr <= a;
    pulse(P_LOAD);
    repeat (n) pulse(P_STEP);
    check("rd_addr", rd_addr, exp);
  endtask
  //////////////////////////////////////////////////
  initial begin
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    repeat (4) @(posedge clk);
    check("wrap_dis", wrap_disable_bit, 1'b1);
    check("latch", write_latch_flag, 1'b0);
    $display("test reset done");
    // Wrap on, 32-byte sections, then four-wire with 16, then back to linear
    frame(OP_WRAP_SET, 32'h0, 32'h40, 8, 1);
    check("wrap_dis", wrap_disable_bit, 1'b0);
    check("wrap_len", wrap_length_field, 2'h2);
    rd_quad_io <= 1'b1;
    rd_try(24'h00011E, 2, 24'h000100);
    four_wire_command_mode <= 1'b1;
    rd_wrapped_cmd <= 1'b1;
    rd_param_len <= 2'h1;
    pulse(P_PLEN);
    check("wrap_len", wrap_length_field, 2'h1);
    rd_try(24'h00010F, 1, 24'h000100);
    four_wire_command_mode <= 1'b0;
    rd_wrapped_cmd <= 1'b0;
    frame(OP_WRAP_SET, 32'h0, 32'h10, 8, 1);
    rd_try(24'h00011F, 1, 24'h000120);
    $display("test wrap done");
    // Erase without latch is dropped; then sector and block erase
    frame(OP_SECT_CLR, 32'h123456, 32'h0, 0, 1);
    check("busy_nolatch", busy_flag, 1'b0);
    pulse(P_WEL);
    check("latch", write_latch_flag, 1'b1);
    frame(OP_SECT_CLR, 32'h123456, 32'h0, 0, 1);
    check("busy", busy_flag, 1'b1);
    check("latch", write_latch_flag, 1'b0);
    check("sect_base", {go_addr, 7'h00, go_blk}, 32'h12300000);
    wait_idle();
    pulse(P_WEL);
    frame(OP_BLK_CLR, 32'h00ABCD, 32'h0, 0, 1);
    check("blk_base", {go_addr, 7'h00, go_blk}, 32'h00800001);
    wait_idle();
    $display("test erase done");
    // Refusals: extra bit after address, protected block, off-byte program, no quad enable
    pulse(P_WEL);
    frame(OP_SECT_CLR, 32'h123456, 32'h1, 1, 1);
    check("busy_extra", busy_flag, 1'b0);
    protect_level_bits <= 5'h01;
    frame(OP_BLK_CLR, 32'hFF1234, 32'h0, 0, 1);
    check("busy_prot", busy_flag, 1'b0);
    protect_level_bits <= 5'h00;
    frame(OP_PAGE_WR, 32'h000200, 32'hABC, 12, 1);
    check("busy_part", busy_flag, 1'b0);
    frame(OP_QPAGE_WR, 32'h000310, 32'h5A6B, 16, 4);
    check("busy_noqe", busy_flag, 1'b0);
    check("latch_kept", write_latch_flag, 1'b1);
    $display("test refuse done");
    // Page write across the page end wraps to offset zero
    frame(OP_PAGE_WR, 32'h0002FE, 32'hA1B2C3, 24, 1);
    wait_idle();
    check("wr_count", wr_q.size(), 3);
    check("wr0", wr_q[0], 32'h000200C3);
    check("wr1", wr_q[1], 32'h0002FEA1);
    check("wr2", wr_q[2], 32'h0002FFB2);
    wr_q.delete();
    quad_io_enable <= 1'b1;
    pulse(P_WEL);
    frame(OP_QPAGE_WR, 32'h000310, 32'h5A6B, 16, 4);
    wait_idle();
    check("qwr_count", wr_q.size(), 2);
    check("qwr0", wr_q[0], 32'h0003105A);
    check("qwr1", wr_q[1], 32'h0003116B);
    $display("test program done");
    finish_test();
  end
  // Watchdog well beyond the expected run
  initial begin
    repeat (60000) @(posedge clk);
    num_errors++;
    finish_test();
  end
endmodule // sfw_flash_seq_bench
